// ### logic/host_port_pin_control.sv
// Purpose: Pin-level control of the parallel host port: ready, interrupt, straps, output-off.
// Assumes: All pin inputs are asynchronous to hclk and pass a two-flop synchroniser.
// Notes:   Registers sit on an AHB-Lite slave; reads take one wait state, writes none.
`include "host_port_defs.svh"

module host_port_pin_control #(
    parameter int BUSY_W = `HP_BUSY_W
) (
    input  wire logic                          hclk,
    input  wire logic                          hresetn,
    input  wire logic                          hsel,
    input  wire logic [31:0]                   haddr,
    input  wire logic [1:0]                    htrans,
    input  wire logic                          hwrite,
    input  wire logic [2:0]                    hsize,
    input  wire logic [31:0]                   hwdata,
    input  wire logic                          hready,
    output logic      [31:0]                   hrdata,
    output logic                               hreadyout,
    output logic                               hresp,
    output logic                               irq,
    input  wire logic                          host_read_not_write,
    input  wire logic                          host_chip_select_n,
    input  wire logic                          host_port_select_strap,
    input  wire logic                          wide_bus_mode_strap,
    input  wire logic                          device_reset_n,
    input  wire logic                          output_off_n,
    output host_port_pkg::pin_drive_type       host_ready_out,
    output host_port_pkg::pin_drive_type       host_irq_out,
    output logic                               port_enable,
    output logic                               bus_keeper_enable,
    output logic                               wide_mode
);
    import host_port_pkg::*;

    ////////////////////////////////////////////////////////////////////////////
    // Pin synchronisation.

    logic [5:0] pins_s;
    logic       rnw_s;
    logic       cs_n_s;
    logic       sel_strap_s;
    logic       wide_s;
    logic       dev_rst_n_s;
    logic       off_n_s;

    // Idle levels: chip select high, device in reset, outputs allowed.
    pin_sync #(
        .WIDTH   (6),
        .RST_VAL (32'h0000_0022)
    ) u_sync (
        .clk      (hclk),
        .rst_n    (hresetn),
        .async_in ({output_off_n, device_reset_n, wide_bus_mode_strap,
                    host_port_select_strap, host_chip_select_n, host_read_not_write}),
        .sync_out (pins_s)
    );

    // Named views of the synchronised pins.
    assign rnw_s       = pins_s[0];
    assign cs_n_s      = pins_s[1];
    assign sel_strap_s = pins_s[2];
    assign wide_s      = pins_s[3];
    assign dev_rst_n_s = pins_s[4];
    assign off_n_s     = pins_s[5];

    ////////////////////////////////////////////////////////////////////////////
    // Select strap capture.

    logic dev_rst_n_prev_q;
    logic select_q;
    logic strap_caught;

    // The strap is caught only on the rising edge of device reset.
    assign strap_caught = dev_rst_n_s && !dev_rst_n_prev_q;

    always_ff @(posedge hclk or negedge hresetn) begin
        if (!hresetn) begin
            dev_rst_n_prev_q <= 1'b0;
        end else begin
            dev_rst_n_prev_q <= dev_rst_n_s;
        end
    end

    // Later strap changes are ignored until the next reset release.
    always_ff @(posedge hclk or negedge hresetn) begin
        if (!hresetn) begin
            select_q <= 1'b0;
        end else if (strap_caught) begin
            select_q <= sel_strap_s;
        end
    end

    // The port lives only while selected and out of device reset.
    assign port_enable       = select_q && dev_rst_n_s;
    assign bus_keeper_enable = !port_enable;
    assign wide_mode         = wide_s;

    ////////////////////////////////////////////////////////////////////////////
    // Register bus address phase.

    logic              ctrl_irq_q;
    logic              ctrl_hold_q;
    logic [BUSY_W-1:0] busy_len_q;
    logic [`HP_EV_W-1:0] event_q;
    logic [`HP_EV_W-1:0] mask_q;
    logic              wr_pend_q;
    logic              rd_pend_q;
    logic [7:0]        addr_q;
    logic              take;
    logic              wr_now;

    // A transfer is taken when selected, active and the bus is ready.
    assign take   = hsel && hready && htrans[1];
    assign wr_now = wr_pend_q;

    always_ff @(posedge hclk or negedge hresetn) begin
        if (!hresetn) begin
            wr_pend_q <= 1'b0;
            rd_pend_q <= 1'b0;
            addr_q    <= 8'h00;
        end else begin
            if (take) begin
                addr_q <= haddr[7:0];
            end
            wr_pend_q <= take && hwrite;
            // A read holds for one wait cycle, so stale read data cannot leak.
            rd_pend_q <= take && !hwrite;
        end
    end

    // Reads insert one wait state; writes finish in their data phase.
    assign hreadyout = !rd_pend_q;
    assign hresp     = 1'b0;

    ////////////////////////////////////////////////////////////////////////////
    // Writable registers.

    always_ff @(posedge hclk or negedge hresetn) begin
        if (!hresetn) begin
            ctrl_irq_q  <= 1'b0;
            ctrl_hold_q <= 1'b0;
        end else if (wr_now && addr_q == `HP_CTRL_OFS) begin
            ctrl_irq_q  <= hwdata[`HP_CTRL_IRQ_BIT];
            ctrl_hold_q <= hwdata[`HP_CTRL_HOLD_BIT];
        end
    end

    always_ff @(posedge hclk or negedge hresetn) begin
        if (!hresetn) begin
            busy_len_q <= BUSY_W'(`HP_BUSY_RST);
        end else if (wr_now && addr_q == `HP_BUSY_OFS) begin
            busy_len_q <= hwdata[BUSY_W-1:0];
        end
    end

    always_ff @(posedge hclk or negedge hresetn) begin
        if (!hresetn) begin
            mask_q <= `HP_MASK_RST;
        end else if (wr_now && addr_q == `HP_MASK_OFS) begin
            mask_q <= hwdata[`HP_EV_W-1:0];
        end
    end

    ////////////////////////////////////////////////////////////////////////////
    // Host access tracking.

    access_state_type  acc_q;
    logic [BUSY_W-1:0] cnt_q;
    logic              cs_n_prev_q;
    logic              rnw_q;
    logic              acc_start;
    logic              acc_end;

    // A new access opens on the falling edge of chip select.
    assign acc_start = port_enable && cs_n_prev_q && !cs_n_s;
    assign acc_end   = (acc_q == ACC_BUSY) && (cnt_q == '0) && !ctrl_hold_q;

    always_ff @(posedge hclk or negedge hresetn) begin
        if (!hresetn) begin
            cs_n_prev_q <= 1'b1;
        end else begin
            cs_n_prev_q <= cs_n_s;
        end
    end

    // The host keeps chip select low for the whole access, so its rise closes it.
    always_ff @(posedge hclk or negedge hresetn) begin
        if (!hresetn) begin
            acc_q <= ACC_IDLE;
        end else if (!port_enable) begin
            acc_q <= ACC_IDLE;
        end else begin
            unique case (acc_q)
                ACC_IDLE: begin
                    if (acc_start) begin
                        acc_q <= ACC_BUSY;
                    end
                end
                ACC_BUSY: begin
                    if (acc_end) begin
                        acc_q <= ACC_DONE;
                    end
                end
                ACC_DONE: begin
                    if (cs_n_s) begin
                        acc_q <= ACC_IDLE;
                    end
                end
                default: begin
                    acc_q <= ACC_IDLE;
                end
            endcase
        end
    end

    // The busy count sets how long ready stays low per access.
    always_ff @(posedge hclk or negedge hresetn) begin
        if (!hresetn) begin
            cnt_q <= '0;
        end else if (acc_start) begin
            cnt_q <= busy_len_q;
        end else if (acc_q == ACC_BUSY && cnt_q != '0) begin
            cnt_q <= cnt_q - BUSY_W'(1);
        end
    end

    // Direction is caught at the start of the access.
    always_ff @(posedge hclk or negedge hresetn) begin
        if (!hresetn) begin
            rnw_q <= 1'b1;
        end else if (acc_start) begin
            rnw_q <= rnw_s;
        end
    end

    ////////////////////////////////////////////////////////////////////////////
    // Ready and interrupt pins.

    logic ready_lvl;

    // Ready is low while an access runs and high once the next may start.
    assign ready_lvl = (acc_q != ACC_BUSY) && !acc_start;

    // Output-off floats ready; a deselected port does not drive it either.
    always_ff @(posedge hclk or negedge hresetn) begin
        if (!hresetn) begin
            host_ready_out <= '{level: 1'b1, oe_n: 1'b1};
        end else begin
            host_ready_out.level <= ready_lvl;
            host_ready_out.oe_n  <= !(off_n_s && port_enable);
        end
    end

    // Interrupt is active low; held high during device reset, floated when wide.
    always_ff @(posedge hclk or negedge hresetn) begin
        if (!hresetn) begin
            host_irq_out <= '{level: 1'b1, oe_n: 1'b0};
        end else begin
            host_irq_out.level <= !dev_rst_n_s || !ctrl_irq_q;
            host_irq_out.oe_n  <= !off_n_s || wide_s;
        end
    end

    ////////////////////////////////////////////////////////////////////////////
    // Event flags and the interrupt line to software.

    logic [`HP_EV_W-1:0] ev_set;
    logic [`HP_EV_W-1:0] ev_clr;

    // Sources of the sticky events.
    always_comb begin
        ev_set = '0;
        ev_set[`HP_EV_READ_BIT]  = acc_start && rnw_s;
        ev_set[`HP_EV_WRITE_BIT] = acc_start && !rnw_s;
        ev_set[`HP_EV_DONE_BIT]  = acc_end;
        ev_set[`HP_EV_STRAP_BIT] = strap_caught;
    end

    assign ev_clr = (wr_now && addr_q == `HP_EVENT_OFS) ? hwdata[`HP_EV_W-1:0] : '0;

    // A new event in the clearing cycle survives, since set wins over clear.
    always_ff @(posedge hclk or negedge hresetn) begin
        if (!hresetn) begin
            event_q <= '0;
        end else begin
            event_q <= (event_q & ~ev_clr) | ev_set;
        end
    end

    assign irq = |(event_q & mask_q);

    ////////////////////////////////////////////////////////////////////////////
    // Read data.

    logic [31:0] rd_mux;

    // Unmapped offsets read as zero.
    always_comb begin
        rd_mux = 32'h0000_0000;
        unique case (addr_q)
            `HP_CTRL_OFS: begin
                rd_mux[`HP_CTRL_IRQ_BIT]  = ctrl_irq_q;
                rd_mux[`HP_CTRL_HOLD_BIT] = ctrl_hold_q;
            end
            `HP_BUSY_OFS: begin
                rd_mux[BUSY_W-1:0] = busy_len_q;
            end
            `HP_STATE_OFS: begin
                rd_mux[`HP_ST_SELECT_BIT] = select_q;
                rd_mux[`HP_ST_WIDE_BIT]   = wide_s;
                rd_mux[`HP_ST_READY_BIT]  = ready_lvl;
                rd_mux[`HP_ST_ACTIVE_BIT] = (acc_q == ACC_BUSY);
                rd_mux[`HP_ST_RNW_BIT]    = rnw_q;
                rd_mux[`HP_ST_OFF_BIT]    = !off_n_s;
                rd_mux[`HP_ST_DEVRST_BIT] = !dev_rst_n_s;
            end
            `HP_EVENT_OFS: begin
                rd_mux[`HP_EV_W-1:0] = event_q;
            end
            `HP_MASK_OFS: begin
                rd_mux[`HP_EV_W-1:0] = mask_q;
            end
            default: begin
                rd_mux = 32'h0000_0000;
            end
        endcase
    end

    // Read data is loaded during the wait cycle and stands in the final one.
    always_ff @(posedge hclk or negedge hresetn) begin
        if (!hresetn) begin
            hrdata <= 32'h0000_0000;
        end else if (rd_pend_q) begin
            hrdata <= rd_mux;
        end
    end

endmodule

// ### logic/host_port_defs.svh
// Purpose: Register map, field positions and reset values of the host port pin control.
// Assumes: One aligned 32-bit word per register on an AHB-Lite bus.
// Notes:   Definitions only.
`ifndef HOST_PORT_DEFS_SVH
`define HOST_PORT_DEFS_SVH

// Register byte offsets.
`define HP_CTRL_OFS        8'h00
`define HP_BUSY_OFS        8'h04
`define HP_STATE_OFS       8'h08
`define HP_EVENT_OFS       8'h0C
`define HP_MASK_OFS        8'h10

// Control register fields.
`define HP_CTRL_IRQ_BIT    0
`define HP_CTRL_HOLD_BIT   1

// Busy length register.
`define HP_BUSY_W          8
`define HP_BUSY_RST        8'h04

// State register fields.
`define HP_ST_SELECT_BIT   0
`define HP_ST_WIDE_BIT     1
`define HP_ST_READY_BIT    2
`define HP_ST_ACTIVE_BIT   3
`define HP_ST_RNW_BIT      4
`define HP_ST_OFF_BIT      5
`define HP_ST_DEVRST_BIT   6

// Event and mask register fields.
`define HP_EV_W            4
`define HP_EV_READ_BIT     0
`define HP_EV_WRITE_BIT    1
`define HP_EV_DONE_BIT     2
`define HP_EV_STRAP_BIT    3
`define HP_MASK_RST        4'h0

`endif

// ### logic/host_port_pkg.sv
// Purpose: Types shared by the host port pin control files.
// Assumes: Nothing beyond the register header.
// Notes:   Holds types only; numbers live in the header.
package host_port_pkg;

    // One three-state pin: level and active-low output enable.
    typedef struct packed {
        logic level;
        logic oe_n;
    } pin_drive_type;

    // Progress of one host access.
    typedef enum logic [1:0] {
        ACC_IDLE = 2'b00,
        ACC_BUSY = 2'b01,
        ACC_DONE = 2'b10
    } access_state_type;

endpackage

// ### logic/pin_sync.sv
// Purpose: Two-flop synchroniser for a group of asynchronous pin levels.
// Assumes: Inputs are slow levels, not single-cycle pulses.
// Notes:   Only the second stage leaves the module.
module pin_sync #(
    parameter int        WIDTH = 1,
    parameter bit [31:0] RST_VAL = 32'h0000_0000
) (
    input  wire logic             clk,
    input  wire logic             rst_n,
    input  wire logic [WIDTH-1:0] async_in,
    output logic      [WIDTH-1:0] sync_out
);

    logic [WIDTH-1:0] meta_q;

    ////////////////////////////////////////////////////////////////////////////
    // Each bit passes two flops; the first stage is read by nothing else.
    always_ff @(posedge clk or negedge rst_n) begin
        if (!rst_n) begin
            meta_q   <= RST_VAL[WIDTH-1:0];
            sync_out <= RST_VAL[WIDTH-1:0];
        end else begin
            meta_q   <= async_in;
            sync_out <= meta_q;
        end
    end

endmodule

// ### test/host_port_pin_control_monitor.sv
// Purpose: Pin-side timing checks of the host port control.
// Assumes: Pins cross two sync flops, outputs add one register.
// Notes:   Repeat counts cover that three-edge pipeline.
module host_port_pin_control_monitor (
    input wire logic                         hclk,
    input wire logic                         hresetn,
    input wire logic                         host_chip_select_n,
    input wire logic                         device_reset_n,
    input wire logic                         output_off_n,
    input wire logic                         wide_bus_mode_strap,
    input wire host_port_pkg::pin_drive_type host_ready_out,
    input wire host_port_pkg::pin_drive_type host_irq_out,
    input wire logic                         port_enable,
    input wire logic                         bus_keeper_enable,
    input wire logic                         wide_mode
);
    timeunit 1ns;
    timeprecision 1ps;

    default clocking @(posedge hclk); endclocking
    default disable iff (!hresetn);

    ////////////////////////////////////////////////////////////////////////
    // Output-off and reset behaviour of the two host pins.
    chk_ready_float:
    assert property (!output_off_n[*4] |-> host_ready_out.oe_n) else $error("ready pin driven");
    chk_irq_float:
    assert property (!output_off_n[*4] |-> host_irq_out.oe_n) else $error("irq pin driven");
    chk_irq_reset:
    assert property ((!device_reset_n && output_off_n && !wide_bus_mode_strap)[*4]
        |-> host_irq_out.level && !host_irq_out.oe_n) else $error("irq pin not high in reset");
    chk_irq_wide:
    assert property (wide_bus_mode_strap[*4] |-> host_irq_out.oe_n) else $error("irq pin in wide");

    ////////////////////////////////////////////////////////////////////////
    // Straps: select only out of reset, held while reset stays high.
    chk_port_reset:
    assert property (!device_reset_n[*3] |-> !port_enable && bus_keeper_enable)
        else $error("port enabled in reset");
    chk_strap_held:
    assert property (device_reset_n[*6] |-> $stable(port_enable)) else $error("strap not held");
    chk_wide_follow:
    assert property (wide_bus_mode_strap[*3] |-> wide_mode) else $error("wide mode missed");
    chk_narrow_follow:
    assert property (!wide_bus_mode_strap[*3] |-> !wide_mode) else $error("narrow mode missed");

    ////////////////////////////////////////////////////////////////////////
    // Ready drops once a fresh access is seen and must come back high.
    chk_ready_busy:
    assert property ((host_chip_select_n && port_enable)[*4] ##1
        (!host_chip_select_n && port_enable)[*4] |-> !host_ready_out.level)
        else $error("ready high during access");
    chk_ready_return:
    assert property ($fell(host_ready_out.level) && port_enable |-> ##[1:300]
        host_ready_out.level) else $error("ready stuck low");

    cover property (port_enable && !host_ready_out.level);
    cover property (!output_off_n && host_irq_out.oe_n);
    cover property (wide_mode && port_enable);
endmodule

bind host_port_pin_control host_port_pin_control_monitor mon (.hclk, .hresetn,
    .host_chip_select_n, .device_reset_n, .output_off_n, .wide_bus_mode_strap,
    .host_ready_out, .host_irq_out, .port_enable, .bus_keeper_enable, .wide_mode);

// ### test/host_model.sv
// Purpose: Behavioural host processor on the parallel port pins.
// Assumes: Ready is sampled at rising edges of hclk.
// Notes:   Released direction line shows the inverse of its last level.
module host_model (
    input wire logic                         hclk,
    input wire host_port_pkg::pin_drive_type host_ready_out,
    output logic                             host_chip_select_n,
    output logic                             host_read_not_write
);
    timeunit 1ns;
    timeprecision 1ps;

    // Idle bus: chip select high.
    initial begin
        host_chip_select_n = 1'b1;
        host_read_not_write = 1'b0;
    end

    // One access; ok says ready went low and came back high.
    task automatic access(input logic rnw, output bit ok);
        int  n;
        bit  low;
        n = 0;
        host_read_not_write <= rnw;
        host_chip_select_n <= 1'b0;
        while (host_ready_out.level !== 1'b0 && n < 20) begin
            @(posedge hclk);
            n++;
        end
        low = (n < 20);
        while (host_ready_out.level !== 1'b1 && n < 400) begin
            @(posedge hclk);
            n++;
        end
        ok = low && (host_ready_out.level === 1'b1);
        host_chip_select_n <= 1'b1;
        host_read_not_write <= ~rnw;
    endtask
endmodule

// ### test/host_port_pin_control_tb.sv
// Purpose: Self-checking bench for the host port pin control.
// Assumes: Pin effects land within four edges; reads take one wait state.
// Notes:   ev_model mirrors the event register and irq level.
`include "host_port_defs.svh"
module host_port_pin_control_tb;
    timeunit 1ns;
    timeprecision 1ps;
    logic                         hclk, hresetn, hsel, hwrite, hready, hreadyout, hresp, irq;
    logic [31:0]                  haddr, hwdata, hrdata, q;
    logic [1:0]                   htrans;
    logic [2:0]                   hsize;
    logic                         cs_n, rnw, sel_strap, wide_strap, dev_rst_n, off_n;
    logic                         port_enable, keeper, wide_mode;
    host_port_pkg::pin_drive_type rdy, hirq;
    int                           n_fail, n_compared, ev_model, m;
    bit                           ok;

    assign hready = hreadyout;

    // Free-running 100 MHz clock.
    initial begin
        hclk = 1'b0;
        forever #5 hclk = ~hclk;
    end

    host_port_pin_control DUT (.hclk, .hresetn, .hsel, .haddr, .htrans, .hwrite, .hsize,
        .hwdata, .hready, .hrdata, .hreadyout, .hresp, .irq, .host_read_not_write(rnw),
        .host_chip_select_n(cs_n), .host_port_select_strap(sel_strap),
        .wide_bus_mode_strap(wide_strap), .device_reset_n(dev_rst_n), .output_off_n(off_n),
        .host_ready_out(rdy), .host_irq_out(hirq), .port_enable,
        .bus_keeper_enable(keeper), .wide_mode);
    host_model host (.hclk, .host_ready_out(rdy), .host_chip_select_n(cs_n),
        .host_read_not_write(rnw));

    ////////////////////////////////////////////////////////////////////////
    // Compare, count and report.
    task automatic check(input string what, input logic [31:0] seen, exp);
        n_compared++;
        if (seen !== exp) begin
            n_fail++;
            $display("CHECK FAILED %s expected %h seen %h", what, exp, seen);
        end
    endtask

    // One AHB-Lite single transfer; read data taken at the data-phase edge.
    task automatic ahb(input logic wr, input logic [31:0] a, d);
        hsel <= 1'b1;
        haddr <= a;
        hwrite <= wr;
        htrans <= 2'b10;
        do @(posedge hclk); while (hready !== 1'b1);
        htrans <= 2'b00;
        hwdata <= d;
        do @(posedge hclk); while (hready !== 1'b1);
        q = hrdata;
    endtask

    task automatic tick(input int n);
        repeat (n) @(posedge hclk);
    endtask

    task automatic test_done;
        $display("Compared %0d, failed %0d", n_compared, n_fail);
        if (n_fail == 0 && n_compared > 0) $display("Regression OK");
        else $display("Regression broken");
        $finish;
    endtask

    // Hang guard, far beyond the few hundred cycles the run needs.
    initial begin
        repeat (20000) @(posedge hclk);
        n_fail++;
        test_done;
    end

    ////////////////////////////////////////////////////////////////////////
    // Main sequence.
    initial begin
        {hresetn, hsel, hwrite, htrans, haddr, hwdata, dev_rst_n, wide_strap} = '0;
        hsize = 3'b010;
        {sel_strap, off_n} = 2'b11;
        {n_fail, n_compared, ev_model} = '0;
        void'($urandom(44));
        tick(12);
        hresetn <= 1'b1;
        tick(1);
        ahb(1'b0, `HP_BUSY_OFS, 0);
        check("busy", q, `HP_BUSY_RST);
        ahb(1'b1, 32'h0000_0014, $urandom);
        ahb(1'b0, 32'h0000_0014, 0);
        check("unmapped", q, 0);
        check("hresp", 32'(hresp), 0);
        check("irq pin", 32'(hirq), 32'h2);
        check("port", 32'({port_enable, keeper}), 32'h1);
        dev_rst_n <= 1'b1;
        tick(6);
        check("port", 32'({port_enable, keeper}), 32'h2);
        ev_model = 8;
        sel_strap <= 1'b0;
        tick(6);
        check("port", 32'(port_enable), 1);
        // Accesses in both directions with random busy lengths.
        for (int i = 0; i < 4; i++) begin
            ahb(1'b1, `HP_BUSY_OFS, 4 + $urandom % 12);
            host.access(i[0], ok);
            check("handshake", 32'(ok), 1);
            ev_model |= (i[0] ? 1 : 2) | 4;
            tick(4);
            ahb(1'b0, `HP_EVENT_OFS, 0);
            check("event", q, ev_model);
        end
        // Hold bit keeps ready low until software lets the access finish.
        ahb(1'b1, `HP_CTRL_OFS, 32'h0000_0002);
        fork
            host.access(1'b1, ok);
            begin
                tick(30);
                check("held", 32'(rdy.level), 0);
                ahb(1'b1, `HP_CTRL_OFS, 0);
            end
        join
        check("handshake", 32'(ok), 1);
        tick(4);
        // Selected, narrow, ready, idle, last access a read, pins on, out of reset.
        ahb(1'b0, `HP_STATE_OFS, 0);
        check("state", q, 32'h0000_0015);
        // Interrupt: random mask, clear of two events, then clear of all by writing ones.
        m = $urandom % 16;
        ahb(1'b1, `HP_MASK_OFS, m);
        tick(1);
        check("irq", 32'(irq), 32'((ev_model & m) != 0));
        ahb(1'b1, `HP_EVENT_OFS, 32'h0000_0005);
        ev_model &= ~5;
        ahb(1'b0, `HP_EVENT_OFS, 0);
        check("event", q, ev_model);
        ahb(1'b1, `HP_EVENT_OFS, 32'h0000_000F);
        tick(1);
        check("irq", 32'(irq), 0);
        ahb(1'b1, `HP_CTRL_OFS, 1);
        tick(4);
        check("irq pin", 32'(hirq), 0);
        ahb(1'b1, `HP_CTRL_OFS, 0);
        // Output-off floats both pins, release drives them again.
        off_n <= 1'b0;
        tick(4);
        check("pins off", 32'({rdy.oe_n, hirq.oe_n}), 3);
        off_n <= 1'b1;
        tick(4);
        check("pins on", 32'({rdy.oe_n, hirq.oe_n}), 0);
        wide_strap <= 1'b1;
        tick(4);
        check("wide", 32'({wide_mode, hirq.oe_n}), 3);
        wide_strap <= 1'b0;
        tick(4);
        check("wide", 32'(wide_mode), 0);
        // New device reset with the strap low deselects the port.
        dev_rst_n <= 1'b0;
        tick(4);
        check("irq pin", 32'(hirq), 32'h2);
        dev_rst_n <= 1'b1;
        tick(6);
        sel_strap <= 1'b1;
        tick(6);
        check("port", 32'({port_enable, keeper}), 32'h1);
        host.access(1'b1, ok);
        check("refused", 32'({ok, rdy.oe_n}), 1);
        tick(4);
        test_done;
    end
endmodule
